// file: design/wrc_map.vh
`ifndef WRC_MAP_VH
`define WRC_MAP_VH
// ----------------------------------------
// global register offsets
// ----------------------------------------
`define WRC_CTRL_OFS 12'h000
`define WRC_DEL_OFS 12'h004
`define WRC_STATE_OFS 12'h008
`define WRC_ISTAT_OFS 12'h00C
`define WRC_IMASK_OFS 12'h010
`define WRC_DOUT_OFS 12'h014
// ----------------------------------------
// register windows
// ----------------------------------------
`define WRC_DENT_WIN 7'h02
`define WRC_CMP_WIN 4'h1
`define WRC_LBL_WIN 3'h1
`define WRC_CFG_SUB 2'h0
`define WRC_LIM_SUB 2'h1
`define WRC_LIMHI_SUB 2'h2
`define WRC_APP_SUB 2'h3
`define WRC_LBL_WORDS 3'h5
// ----------------------------------------
// field positions
// ----------------------------------------
`define WRC_CTRL_CLR_CMP 0
`define WRC_CTRL_CLR_DENT 1
`define WRC_CFG_SRC_LSB 0
`define WRC_CFG_REL_LSB 4
`define WRC_CFG_MASK 32'h00000077
`define WRC_DENT_MASK 20'hF0FFF
`define WRC_DENT_ASG_LSB 16
// ----------------------------------------
// source codes
// ----------------------------------------
`define WRC_SRC_NONE 3'h0
`define WRC_SRC_ABS_SHOWN 3'h1
`define WRC_SRC_ABS_FLOW_RATE_SOURCE 3'h2
`define WRC_SRC_APP 3'h3
`define WRC_SRC_SHOWN 3'h4
`define WRC_SRC_GROSS 3'h5
`define WRC_SRC_RATE 3'h6
// ----------------------------------------
// relation codes
// ----------------------------------------
`define WRC_REL_LT 3'h0
`define WRC_REL_LE 3'h1
`define WRC_REL_EQ 3'h2
`define WRC_REL_GE 3'h3
`define WRC_REL_GT 3'h4
`define WRC_REL_NE 3'h5
`define WRC_REL_OUT 3'h6
`define WRC_REL_IN 3'h7
// ----------------------------------------
// output address digits
// ----------------------------------------
`define WRC_IO_LOCAL 4'h0
`define WRC_IO_REMOTE 4'h1
`define WRC_REMOTE_MODS 4'h3
`define WRC_POINTS 4'h8
// ----------------------------------------
// reset values
// ----------------------------------------
`define WRC_REG_RST 32'h00000000
`define WRC_DENT_RST 20'h00000
`endif

// file: design/wrc_label_mem.v
`timescale 1ns/100ps
// ----------------------------------------
// label text store, registered read
// ----------------------------------------
module wrc_label_mem (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire we,
  input wire [5:0] waddr,
  input wire [31:0] wdata,
  input wire [5:0] raddr,
  output reg [31:0] rdata
);
  reg [31:0] mem [0:63];

  always @(posedge pclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 32'h00000000;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule // wrc_label_mem

// file: design/wrc_top.v
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "wrc_map.vh"
module wrc_top (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [31:0] gross_weight,
  input wire [31:0] shown_weight,
  input wire [31:0] flow_rate,
  output wire [7:0] local_out,
  output wire [23:0] remote_out,
  output reg irq
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [31:0] abs32;
    input [31:0] v;
    begin
      abs32 = v[31] ? (32'h00000000 - v) : v;
    end
  endfunction

  function rel_test;
    input [2:0] rel;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      case (rel)
        `WRC_REL_LT: rel_test = v < lo;
        `WRC_REL_LE: rel_test = v <= lo;
        `WRC_REL_EQ: rel_test = v == lo;
        `WRC_REL_GE: rel_test = v >= lo;
        `WRC_REL_GT: rel_test = v > lo;
        `WRC_REL_NE: rel_test = v != lo;
        `WRC_REL_OUT: rel_test = (v < lo) || (v > hi);
        `WRC_REL_IN: rel_test = (v >= lo) && (v <= hi);
        default: rel_test = 1'b0;
      endcase
    end
  endfunction

  // returns {valid, point index}
  function [5:0] phys_idx;
    input [11:0] a;
    reg [3:0] pt_m1;
    begin
      pt_m1 = a[3:0] - 4'h1;
      phys_idx = 6'h00;
      if (a[3:0] != 4'h0 && a[3:0] <= `WRC_POINTS) begin
        if (a[11:8] == `WRC_IO_LOCAL) begin
          phys_idx = {1'b1, 2'b00, pt_m1[2:0]};
        end else if (a[11:8] == `WRC_IO_REMOTE && a[7:4] != 4'h0 &&
                     a[7:4] <= `WRC_REMOTE_MODS) begin
          phys_idx = {1'b1, a[5:4], pt_m1[2:0]};
        end
      end
    end
  endfunction

  // ----------------------------------------
  // bus strobes
  // ----------------------------------------
  wire acc = psel & penable;
  wire wr_en = acc & pready & pwrite & ce;
  wire lbl_win = (paddr[11:9] == `WRC_LBL_WIN) && !paddr[8];
  wire lbl_ok = lbl_win && (paddr[4:2] < `WRC_LBL_WORDS);
  wire cmp_win = (paddr[11:8] == `WRC_CMP_WIN) && !paddr[7];
  wire dent_win = (paddr[11:5] == `WRC_DENT_WIN);
  wire clr_cmp = wr_en && paddr == `WRC_CTRL_OFS &&
                 pwdata[`WRC_CTRL_CLR_CMP];
  wire clr_dent = wr_en && paddr == `WRC_CTRL_OFS &&
                  pwdata[`WRC_CTRL_CLR_DENT];
  wire del_hit = wr_en && paddr == `WRC_DEL_OFS;
  wire [31:0] lbl_rdata;

  // ----------------------------------------
  // comparators
  // ----------------------------------------
  wire [255:0] cfg_bus;
  wire [255:0] lim_bus;
  wire [255:0] limhi_bus;
  wire [255:0] app_bus;
  wire [7:0] next_comp;
  reg [7:0] comp_q;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_cmp
      reg [31:0] cfg;
      reg [31:0] lim;
      reg [31:0] lim_hi;
      reg [31:0] app_val;
      reg [31:0] src_val;
      wire sel = wr_en && cmp_win && paddr[6:4] == i;
      wire kill = clr_cmp || (del_hit && pwdata[2:0] == i);
      wire [2:0] src = cfg[`WRC_CFG_SRC_LSB +: 3];
      wire [2:0] rel = cfg[`WRC_CFG_REL_LSB +: 3];

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg <= `WRC_REG_RST;
          lim <= `WRC_REG_RST;
          lim_hi <= `WRC_REG_RST;
          app_val <= `WRC_REG_RST;
        end else if (ce) begin
          if (kill) begin
            cfg <= `WRC_REG_RST;
            lim <= `WRC_REG_RST;
            lim_hi <= `WRC_REG_RST;
            app_val <= `WRC_REG_RST;
          end else if (sel) begin
            case (paddr[3:2])
              `WRC_CFG_SUB: cfg <= pwdata & `WRC_CFG_MASK;
              `WRC_LIM_SUB: lim <= pwdata;
              `WRC_LIMHI_SUB: lim_hi <= pwdata;
              `WRC_APP_SUB: app_val <= pwdata;
              default: cfg <= cfg;
            endcase
          end
        end
      end

      always @* begin
        case (src)
          `WRC_SRC_ABS_SHOWN: src_val = abs32(shown_weight);
          `WRC_SRC_ABS_FLOW_RATE_SOURCE: src_val = abs32(flow_rate);
          `WRC_SRC_APP: src_val = app_val;
          `WRC_SRC_SHOWN: src_val = shown_weight;
          `WRC_SRC_GROSS: src_val = gross_weight;
          `WRC_SRC_RATE: src_val = flow_rate;
          default: src_val = 32'h00000000;
        endcase
      end

      // plain level test, no memory of the previous state
      assign next_comp[i] = (src != `WRC_SRC_NONE) &&
                            (src <= `WRC_SRC_RATE) &&
                            rel_test(rel, src_val, lim, lim_hi);
      assign cfg_bus[i*32 +: 32] = cfg;
      assign lim_bus[i*32 +: 32] = lim;
      assign limhi_bus[i*32 +: 32] = lim_hi;
      assign app_bus[i*32 +: 32] = app_val;
    end
  endgenerate

  // ----------------------------------------
  // output assignment table
  // ----------------------------------------
  wire [159:0] dent_bus;
  genvar j;
  generate
    for (j = 0; j < 8; j = j + 1) begin : g_dent
      reg [19:0] dent;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dent <= `WRC_DENT_RST;
        end else if (ce) begin
          if (clr_dent) begin
            dent <= `WRC_DENT_RST;
          end else if (wr_en && dent_win && paddr[4:2] == j) begin
            dent <= pwdata[19:0] & `WRC_DENT_MASK;
          end
        end
      end
      assign dent_bus[j*20 +: 20] = dent;
    end
  endgenerate

  reg [31:0] next_dout;
  reg [31:0] dout_q;
  reg [5:0] pv;
  reg [3:0] asg;
  reg [3:0] asg_m1;
  integer k;
  always @* begin
    next_dout = 32'h00000000;
    pv = 6'h00;
    asg = 4'h0;
    asg_m1 = 4'h0;
    for (k = 0; k < 8; k = k + 1) begin
      pv = phys_idx(dent_bus[k*20 +: 12]);
      asg = dent_bus[k*20 + `WRC_DENT_ASG_LSB +: 4];
      asg_m1 = asg - 4'h1;
      if (pv[5] && asg != 4'h0 && asg <= 4'h8) begin
        next_dout[pv[4:0]] = next_dout[pv[4:0]] |
                             next_comp[asg_m1[2:0]];
      end
    end
  end

  // ----------------------------------------
  // state, outputs, interrupt
  // ----------------------------------------
  reg [7:0] istat;
  reg [7:0] imask;
  wire [7:0] rise = next_comp & ~comp_q;
  wire [7:0] w1c = (wr_en && paddr == `WRC_ISTAT_OFS) ?
                   pwdata[7:0] : 8'h00;
  wire [7:0] next_istat = (istat & ~w1c) | rise;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_q <= 8'h00;
      dout_q <= 32'h00000000;
      istat <= 8'h00;
      imask <= 8'h00;
      irq <= 1'b0;
    end else if (ce) begin
      comp_q <= next_comp;
      dout_q <= next_dout;
      istat <= next_istat;
      if (wr_en && paddr == `WRC_IMASK_OFS) begin
        imask <= pwdata[7:0];
      end
      irq <= |(next_istat & imask);
    end
  end

  assign local_out = dout_q[7:0];
  assign remote_out = dout_q[31:8];

  // ----------------------------------------
  // label store
  // ----------------------------------------
  wrc_label_mem u_lbl (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .we(wr_en && lbl_ok),
    .waddr({paddr[7:5], paddr[4:2]}),
    .wdata(pwdata),
    .raddr({paddr[7:5], paddr[4:2]}),
    .rdata(lbl_rdata)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [31:0] next_rdata;
  reg hit;
  always @* begin
    next_rdata = 32'h00000000;
    hit = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (paddr == `WRC_CTRL_OFS || paddr == `WRC_DEL_OFS) begin
      next_rdata = 32'h00000000;
    end else if (paddr == `WRC_STATE_OFS) begin
      next_rdata = {24'h000000, comp_q};
    end else if (paddr == `WRC_ISTAT_OFS) begin
      next_rdata = {24'h000000, istat};
    end else if (paddr == `WRC_IMASK_OFS) begin
      next_rdata = {24'h000000, imask};
    end else if (paddr == `WRC_DOUT_OFS) begin
      next_rdata = dout_q;
    end else if (dent_win) begin
      next_rdata = {12'h000, dent_bus[paddr[4:2]*20 +: 20]};
    end else if (cmp_win) begin
      case (paddr[3:2])
        `WRC_CFG_SUB: next_rdata = cfg_bus[paddr[6:4]*32 +: 32];
        `WRC_LIM_SUB: next_rdata = lim_bus[paddr[6:4]*32 +: 32];
        `WRC_LIMHI_SUB: next_rdata = limhi_bus[paddr[6:4]*32 +: 32];
        `WRC_APP_SUB: next_rdata = app_bus[paddr[6:4]*32 +: 32];
        default: next_rdata = 32'h00000000;
      endcase
    end else if (lbl_ok) begin
      next_rdata = lbl_rdata;
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------
  // apb handshake: one wait state on every access
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (acc && !pready) begin
        pready <= 1'b1;
        pslverr <= ~hit;
        if (!pwrite) begin
          prdata <= hit ? next_rdata : 32'h00000000;
        end
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule // wrc_top

// file: dv/wrc_top_checker.sv
`timescale 1ns/100ps
`include "wrc_map.vh"
module wrc_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] gross_weight,
  input wire logic [31:0] shown_weight,
  input wire logic [31:0] flow_rate,
  input wire logic [7:0] local_out,
  input wire logic [23:0] remote_out,
  input wire logic irq
);
  wire wr_req = psel && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  chk_ready_after:
    assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready not one cycle after access edge");
  chk_ready_once:
    assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_access:
    assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_err_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_zero:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_ctrl_zero:
    assert property (pready && !pwrite && paddr == `WRC_CTRL_OFS
      |-> prdata == 32'h0)
    else $error("control word read not zero");
  // ----------------------------------------
  // outputs and interrupt
  // ----------------------------------------
  chk_irq_fall:
    assert property ($fell(irq) |-> $past(wr_req) || $past(wr_req, 2)
      || $past(wr_req, 3))
    else $error("irq fell without a register write");
  chk_out_quiet:
    assert property ((ce && !psel && $stable(gross_weight)
      && $stable(shown_weight) && $stable(flow_rate)) [*4]
      |=> $stable(local_out) && $stable(remote_out))
    else $error("outputs moved without a cause");
endmodule // wrc_top_checker

// file: dv/wrc_lamp_model.sv
`timescale 1ns/100ps
module wrc_lamp_model #(parameter int LAG = 2) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] local_out,
  output logic blank_req
);
  logic [7:0] pipe;
  // output point 1 wired back to a display blanking input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) pipe <= 8'h00;
    else pipe <= {pipe[6:0], local_out[0]};
  end
  assign blank_req = pipe[LAG-1];
endmodule // wrc_lamp_model

// file: dv/wrc_top_bench.sv
`timescale 1ns/100ps
`include "wrc_map.vh"
module wrc_top_bench;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, gross_weight = '0, shown_weight = '0;
  logic [31:0] flow_rate = '0, prdata, rq, seed = 32'h3071;
  logic pready, pslverr, irq, re, blank_req;
  logic [7:0] local_out;
  logic [23:0] remote_out;
  int n_errors = 0, compares = 0, cyc = 0, lbl[5];
  int cv[5] = '{99, 100, 101, 200, 201};
  logic [11:0] bad[3] = '{12'h018, 12'h214, 12'h102};
  always #2.5 pclk = ~pclk;
  wrc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gross_weight(gross_weight), .shown_weight(shown_weight),
    .flow_rate(flow_rate), .local_out(local_out),
    .remote_out(remote_out), .irq(irq));
  wrc_lamp_model #(.LAG(2)) lamp (.pclk(pclk), .presetn(presetn),
    .local_out(local_out), .blank_req(blank_req));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    check(rq, e);
  endtask
  task settle;
    repeat (2) @(posedge pclk);
  endtask
  function int rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[10:0]) - 1024;
  endfunction
  function logic exp_rel(input int v, lo, hi, input logic [2:0] r);
    case (r)
      3'h0: return v < lo;
      3'h1: return v <= lo;
      3'h2: return v == lo;
      3'h3: return v >= lo;
      3'h4: return v > lo;
      3'h5: return v != lo;
      3'h6: return v < lo || v > hi;
      default: return v >= lo && v <= hi;
    endcase
  endfunction
  function int src_val(input logic [2:0] s, input int app);
    int d, f;
    d = shown_weight;
    f = flow_rate;
    case (s)
      3'h1: return d < 0 ? -d : d;
      3'h2: return f < 0 ? -f : f;
      3'h3: return app;
      3'h4: return d;
      3'h5: return gross_weight;
      default: return f;
    endcase
  endfunction
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report;
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int v, lo, a;
    logic [2:0] r;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (6) @(posedge pclk);
    check({remote_out, local_out}, 32'h0);
    rd(`WRC_STATE_OFS, 32'h0);
    rd(`WRC_DOUT_OFS, 32'h0);
    rd(`WRC_CTRL_OFS, 32'h0);
    foreach (bad[i]) begin
      rd(bad[i], 32'h0);
      check(re, 1'b1);
    end
    $display("reset and refusal test done");
    wr(12'h040, 32'h00010001);
    wr(12'h104, 100);
    wr(12'h108, 200);
    for (int i = 0; i < 8; i++) begin
      r = i;
      wr(12'h100, {25'h0, r, 4'h5});
      for (int k = 0; k < 8; k++) begin
        v = k < 5 ? cv[k] : rnd() / 4 + 150;
        gross_weight <= v;
        settle;
        check(local_out[0], exp_rel(v, 100, 200, r));
        rd(`WRC_STATE_OFS, {31'h0, exp_rel(v, 100, 200, r)});
      end
    end
    $display("relation test done");
    for (int i = 0; i < 21; i++) begin
      r = i % 8;
      a = rnd();
      lo = rnd();
      wr(12'h100, {25'h0, 3'h3, 1'b0, r});
      wr(12'h104, lo);
      wr(12'h10C, a);
      gross_weight <= rnd();
      shown_weight <= rnd();
      flow_rate <= rnd();
      settle;
      check(local_out[0], r != 0 && r != 7 && src_val(r, a) >= lo);
    end
    $display("source test done");
    wr(12'h100, 32'h00000035);
    wr(12'h104, 0);
    wr(12'h110, 32'h00000035);
    gross_weight <= 5;
    wr(12'h044, 32'h00010138);
    wr(12'h048, 32'h00010148);
    wr(12'h04C, 32'h00090002);
    settle;
    check({remote_out, local_out}, 32'h80000001);
    rd(`WRC_DOUT_OFS, 32'h80000001);
    wr(`WRC_CTRL_OFS, 32'h2);
    settle;
    check({remote_out, local_out}, 32'h0);
    rd(`WRC_STATE_OFS, 32'h3);
    wr(`WRC_DEL_OFS, 32'h0);
    rd(`WRC_STATE_OFS, 32'h2);
    wr(`WRC_CTRL_OFS, 32'h1);
    rd(`WRC_STATE_OFS, 32'h0);
    $display("output map test done");
    wr(12'h040, 32'h00010001);
    wr(12'h100, 32'h00000035);
    wr(12'h104, 100);
    gross_weight <= 0;
    settle;
    wr(`WRC_ISTAT_OFS, 32'hFF);
    wr(`WRC_IMASK_OFS, 32'h1);
    gross_weight <= 150;
    settle;
    check({irq, local_out}, 9'h101);
    rd(`WRC_ISTAT_OFS, 32'h1);
    wr(`WRC_IMASK_OFS, 32'h0);
    settle;
    check(irq, 1'b0);
    wr(`WRC_IMASK_OFS, 32'h1);
    settle;
    check(irq, 1'b1);
    wr(`WRC_ISTAT_OFS, 32'h1);
    settle;
    check(irq, 1'b0);
    check(blank_req, 1'b1);
    gross_weight <= 99;
    settle;
    check(local_out, 8'h00);
    settle;
    check(blank_req, 1'b0);
    ce <= 0;
    gross_weight <= 150;
    repeat (3) @(posedge pclk);
    check(local_out, 8'h00);
    ce <= 1;
    settle;
    check(local_out, 8'h01);
    $display("interrupt test done");
    for (int w = 0; w < 5; w++) begin
      lbl[w] = rnd();
      wr(12'h200 + 12'(4 * w), lbl[w]);
    end
    for (int w = 0; w < 5; w++) rd(12'h200 + 12'(4 * w), lbl[w]);
    $display("label test done");
    final_report;
  end
endmodule // wrc_top_bench
bind wrc_top wrc_top_checker chk (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gross_weight(gross_weight), .shown_weight(shown_weight),
  .flow_rate(flow_rate), .local_out(local_out), .remote_out(remote_out),
  .irq(irq));
